//--- rtl/sar_adc_pkg.sv
package sar_adc_pkg;
	localparam int CODE_W       = 10;
	localparam int RESULT_W     = 16;
	localparam int RESULT_SHIFT = 6;
	localparam int UPPER_W      = 8;
	localparam int CHAN_W       = 3;
	localparam int PIN_W        = 4;
	localparam int TIME_W       = 5;
	localparam int STEP_W       = 8;
	localparam int ADDR_W       = 8;
	localparam int DATA_W       = 32;

	localparam logic [ADDR_W-1:0] MODE_OFS   = 8'h00;
	localparam logic [ADDR_W-1:0] CHAN_OFS   = 8'h04;
	localparam logic [ADDR_W-1:0] PIN_OFS    = 8'h08;
	localparam logic [ADDR_W-1:0] RESULT_OFS = 8'h0C;
	localparam logic [ADDR_W-1:0] UPPER_OFS  = 8'h10;
	localparam logic [ADDR_W-1:0] FLAG_OFS   = 8'h14;
	localparam logic [ADDR_W-1:0] PORT2_OFS  = 8'h18;
	localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h1C;

	localparam int MODE_START_BIT  = 7;
	localparam int MODE_TIME_MSB   = 5;
	localparam int MODE_TIME_LSB   = 1;
	localparam int MODE_ENABLE_BIT = 0;
	localparam int FLAG_IRQ_BIT    = 0;
	localparam int STAT_BUSY_BIT   = 0;
	localparam int STAT_SETTLE_BIT = 1;
	localparam int STAT_SUSPECT_BIT = 2;

	localparam logic [7:0]          MODE_WR_MASK = 8'hBF;
	localparam logic [7:0]          MODE_RST     = 8'h00;
	localparam logic [CHAN_W-1:0]   CHAN_RST     = 3'h0;
	localparam logic [PIN_W-1:0]    PIN_RST      = 4'h0;
	localparam logic [7:0]          PORT2_RST    = 8'hFF;
	localparam logic [RESULT_W-1:0] RESULT_RST   = 16'h0000;
	localparam logic [UPPER_W-1:0]  UPPER_RST    = 8'h00;
	localparam logic [DATA_W-1:0]   UNMAPPED_RD  = 32'h0000_0000;

	localparam logic [STEP_W-1:0] STEP_MIN = 8'h04;
	localparam logic [CODE_W-1:0] CODE_ONE = 10'h001;
	localparam logic [3:0]        TOP_IDX  = 4'h9;

	localparam int CLK_PERIOD_NS = 4;
	localparam int SETTLE_NS     = 1000;
	localparam int SETTLE_CYCLES = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETTLE_W      = 9;

	typedef enum logic [1:0] {
		SEQ_IDLE    = 2'b00,
		SEQ_SAMPLE  = 2'b01,
		SEQ_COMPARE = 2'b10
	} seq_state_type;
endpackage

//--- rtl/sar_step_if.sv
interface sar_step_if;
	import sar_adc_pkg::*;
	logic              run;
	logic              restart;
	logic [STEP_W-1:0] step_len;
	logic              cmp_bit;
	logic [CODE_W-1:0] tap_code;
	logic              sampling;
	logic              busy;
	logic              done;
	logic [CODE_W-1:0] code;
	modport ctrl (output run, restart, step_len, cmp_bit,
		input tap_code, sampling, busy, done, code);
	modport seq (input run, restart, step_len, cmp_bit,
		output tap_code, sampling, busy, done, code);
endinterface

//--- rtl/sar_step_sequencer.sv
module sar_step_sequencer (
	input wire logic core_clk_in,
	input wire logic rst_n_in,
	sar_step_if.seq  step
);
	import sar_adc_pkg::*;

	seq_state_type     state;
	logic [STEP_W-1:0] timer;
	logic [3:0]        bit_idx;
	logic [CODE_W-1:0] approximation_shift_reg;
	logic              step_end;
	logic              last_step;

	assign step_end  = (state != SEQ_IDLE) && (timer == 8'h00);
	assign last_step = step_end && (state == SEQ_COMPARE) && (bit_idx == 4'h0);

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state <= SEQ_IDLE;
		end else if (!step.run) begin
			state <= SEQ_IDLE; // RULE7
		end else if (step.restart) begin
			state <= SEQ_SAMPLE; // RULE6
		end else begin
			case (state)
				SEQ_IDLE:    state <= SEQ_SAMPLE; // RULE3
				SEQ_SAMPLE:  if (step_end) state <= SEQ_COMPARE;
				SEQ_COMPARE: if (last_step) state <= SEQ_SAMPLE; // RULE5
				default:     state <= SEQ_IDLE;
			endcase
		end
	end

	// each phase lasts step_len cycles
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			timer <= 8'h00;
		end else if (!step.run || step.restart || state == SEQ_IDLE || step_end) begin
			timer <= step.step_len - 8'h01; // RULE21
		end else begin
			timer <= timer - 8'h01;
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			bit_idx <= TOP_IDX;
		end else if (state != SEQ_COMPARE || step.restart) begin
			bit_idx <= TOP_IDX;
		end else if (step_end && bit_idx != 4'h0) begin
			bit_idx <= bit_idx - 4'h1; // RULE17
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			approximation_shift_reg <= '0;
		end else if (state != SEQ_COMPARE || step.restart) begin
			approximation_shift_reg <= '0;
		end else if (step_end) begin
			approximation_shift_reg[bit_idx] <= step.cmp_bit; // RULE17
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			step.done <= 1'b0;
			step.code <= '0;
		end else begin
			step.done <= last_step && step.run && !step.restart;
			if (last_step) begin
				step.code <= {approximation_shift_reg[CODE_W-1:1], step.cmp_bit};
			end
		end
	end

	// trial bit raised on top of the bits already resolved
	assign step.tap_code = (state == SEQ_COMPARE) ?
		(approximation_shift_reg | (CODE_ONE << bit_idx)) : approximation_shift_reg;
	assign step.sampling = (state == SEQ_SAMPLE);
	assign step.busy     = (state != SEQ_IDLE);
endmodule

//--- rtl/sar_adc_select_mode_control.sv
// How it works
// (RULE1) result word holds the 10-bit code times 64, left-justified.
// (RULE2) only the one channel named by the channel register is converted.
// (RULE3) setting start bit 7 of the mode register begins conversion.
// (RULE4) each finished conversion stores the result and raises the end event.
// (RULE5) while start stays set, the next conversion follows at once.
// (RULE6) writing the channel register mid-conversion restarts from the beginning.
// (RULE7) clearing start stops at once and keeps the previous result.
// (RULE8) channel number is bits 2 down to 0 of the channel register.
// (RULE9) conversion time is mode bits 5 down to 1.
// (RULE10) software enables the comparator at least 1 us before starting.
// (RULE11) software discards the first result if started without the comparator.
// (RULE12) channel change to next end event takes the programmed time plus one clock.
// (RULE13) a result read coinciding with an update wins; update follows.
// (RULE14) a config write coinciding with an update drops result and event.
// (RULE15) software sets used pins analog and their port bits to input.
// (RULE16) software clears the event flag before resuming from standby.
// (RULE17) code is resolved one bit per step, bit 9 down to bit 0.
// (RULE18) an 8-bit upper copy of the result updates together with it.
// (RULE19) reset clears the result word and the upper byte to zero.
// (RULE20) with the comparator off, comparisons are invalid but sequencing continues.
// (RULE21) sampling and ten steps are paced from the clock by the time setting.
module sar_adc_select_mode_control (
	input  wire logic                             core_clk_in,
	input  wire logic                             rst_n_in,
	input  wire logic [sar_adc_pkg::ADDR_W-1:0]   avs_address_in,
	input  wire logic                             avs_read_in,
	input  wire logic                             avs_write_in,
	input  wire logic [sar_adc_pkg::DATA_W-1:0]   avs_writedata_in,
	input  wire logic [3:0]                       avs_byteenable_in,
	output logic      [sar_adc_pkg::DATA_W-1:0]   avs_readdata_out,
	output logic                                  avs_waitrequest_out,
	input  wire logic                             comparator_in,
	output logic      [sar_adc_pkg::CODE_W-1:0]   tap_code_out,
	output logic                                  sample_hold_out,
	output logic      [sar_adc_pkg::CHAN_W-1:0]   channel_number_out,
	output logic                                  comparator_power_out,
	output logic      [sar_adc_pkg::PIN_W-1:0]    analog_pin_count_out,
	output logic      [7:0]                       port2_direction_bits_out,
	output logic                                  conversion_end_irq_out,
	output logic                                  conversion_irq_flag_out
);
	import sar_adc_pkg::*;

	sar_step_if step ();

	logic                ack;
	logic                req;
	logic                wr_take;
	logic                rd_cap;
	logic                mode_wr;
	logic                chan_wr;
	logic                pin_wr;
	logic                flag_wr;
	logic                port2_wr;
	logic                cfg_wr;
	logic                rd_result;
	logic [7:0]          converter_mode_reg;
	logic [CHAN_W-1:0]   channel_select_reg;
	logic [PIN_W-1:0]    analog_pin_config_reg;
	logic [7:0]          port2_direction_reg;
	logic [RESULT_W-1:0] result_word_16;
	logic [UPPER_W-1:0]  result_upper_byte;
	logic                conversion_irq_flag;
	logic                next_start;
	logic                cmp_meta;
	logic                cmp_sync;
	logic                cmp_valid;
	logic                suspect;
	logic                pend;
	logic [CODE_W-1:0]   pend_code;
	logic                store;
	logic [CODE_W-1:0]   store_code;
	logic                accept_done;
	logic [SETTLE_W-1:0] settle_cnt;
	logic                settled;
	logic [TIME_W-1:0]   conv_time;
	logic [TIME_W-1:0]   next_time;
	logic [DATA_W-1:0]   next_readdata;

	// bus handshake: one wait cycle per access
	assign req                 = avs_read_in | avs_write_in;
	assign avs_waitrequest_out = req & ~ack;
	assign rd_cap              = avs_read_in & ~ack;
	assign wr_take             = avs_write_in & ack & avs_byteenable_in[0];

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ack <= 1'b0;
		end else begin
			ack <= req & ~ack;
		end
	end

	assign mode_wr  = wr_take && (avs_address_in == MODE_OFS);
	assign chan_wr  = wr_take && (avs_address_in == CHAN_OFS);
	assign pin_wr   = wr_take && (avs_address_in == PIN_OFS);
	assign flag_wr  = wr_take && (avs_address_in == FLAG_OFS);
	assign port2_wr = wr_take && (avs_address_in == PORT2_OFS);
	assign cfg_wr   = mode_wr | chan_wr | pin_wr;
	assign rd_result = rd_cap &&
		((avs_address_in == RESULT_OFS) || (avs_address_in == UPPER_OFS));

	// mode register
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			converter_mode_reg <= MODE_RST;
		end else if (mode_wr) begin
			converter_mode_reg <= avs_writedata_in[7:0] & MODE_WR_MASK; // RULE3
		end
	end

	assign conv_time = converter_mode_reg[MODE_TIME_MSB:MODE_TIME_LSB]; // RULE9
	// new time applies from the start edge itself
	assign next_time = mode_wr ? avs_writedata_in[MODE_TIME_MSB:MODE_TIME_LSB] :
		conv_time; // RULE9
	assign next_start = mode_wr ? avs_writedata_in[MODE_START_BIT] :
		converter_mode_reg[MODE_START_BIT];

	// channel register
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			channel_select_reg <= CHAN_RST;
		end else if (chan_wr) begin
			channel_select_reg <= avs_writedata_in[CHAN_W-1:0]; // RULE8
		end
	end

	// pin configuration and port direction
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			analog_pin_config_reg <= PIN_RST;
		end else if (pin_wr) begin
			analog_pin_config_reg <= avs_writedata_in[PIN_W-1:0];
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			port2_direction_reg <= PORT2_RST;
		end else if (port2_wr) begin
			port2_direction_reg <= avs_writedata_in[7:0];
		end
	end

	// comparator pin synchroniser
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cmp_meta <= 1'b0;
			cmp_sync <= 1'b0;
		end else begin
			cmp_meta <= comparator_in;
			cmp_sync <= cmp_meta;
		end
	end

	// comparator validity caught while sampling
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			cmp_valid <= 1'b0;
		end else if (step.sampling) begin
			cmp_valid <= converter_mode_reg[MODE_ENABLE_BIT]; // RULE20
		end
	end

	// settle time after comparator enable
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			settle_cnt <= '0;
		end else if (!converter_mode_reg[MODE_ENABLE_BIT]) begin
			settle_cnt <= '0;
		end else if (!settled) begin
			settle_cnt <= settle_cnt + 9'h001; // RULE10
		end
	end

	assign settled = (settle_cnt >= SETTLE_W'(SETTLE_CYCLES));

	// sequencer connection
	assign step.run      = next_start; // RULE7
	assign step.restart  = chan_wr; // RULE6
	assign step.step_len = STEP_MIN + {3'h0, next_time}; // RULE21
	assign step.cmp_bit  = cmp_sync & cmp_valid; // RULE20

	sar_step_sequencer sequencer (
		.core_clk_in (core_clk_in),
		.rst_n_in    (rst_n_in),
		.step        (step)
	);

	// result update with read and write priority
	assign accept_done = step.done && !cfg_wr; // RULE14
	assign store       = (accept_done && !rd_result) || pend;
	assign store_code  = pend ? pend_code : step.code;

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pend      <= 1'b0;
			pend_code <= '0;
		end else begin
			pend <= accept_done && rd_result; // RULE13
			if (accept_done) begin
				pend_code <= step.code;
			end
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			result_word_16    <= RESULT_RST; // RULE19
			result_upper_byte <= UPPER_RST; // RULE19
		end else if (store) begin
			result_word_16    <= {store_code, 6'h00}; // RULE1
			result_upper_byte <= store_code[CODE_W-1:CODE_W-UPPER_W]; // RULE18
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			suspect <= 1'b0;
		end else if (accept_done) begin
			suspect <= !cmp_valid; // RULE11
		end
	end

	// end event pulse and sticky flag, set wins over clear
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			conversion_end_irq_out <= 1'b0;
		end else begin
			conversion_end_irq_out <= accept_done; // RULE4
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			conversion_irq_flag <= 1'b0;
		end else if (accept_done) begin
			conversion_irq_flag <= 1'b1; // RULE4
		end else if (flag_wr && !avs_writedata_in[FLAG_IRQ_BIT]) begin
			conversion_irq_flag <= 1'b0; // RULE16
		end
	end

	// read data mux
	always_comb begin
		next_readdata = UNMAPPED_RD;
		case (avs_address_in)
			MODE_OFS:   next_readdata = {24'h000000, converter_mode_reg};
			CHAN_OFS:   next_readdata = {29'h00000000, channel_select_reg};
			PIN_OFS:    next_readdata = {28'h0000000, analog_pin_config_reg};
			RESULT_OFS: next_readdata = {16'h0000, result_word_16};
			UPPER_OFS:  next_readdata = {24'h000000, result_upper_byte};
			FLAG_OFS:   next_readdata = {31'h00000000, conversion_irq_flag};
			PORT2_OFS:  next_readdata = {24'h000000, port2_direction_reg};
			STATUS_OFS: next_readdata = {29'h00000000, suspect, settled, step.busy};
			default:    next_readdata = UNMAPPED_RD;
		endcase
	end

	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			avs_readdata_out <= UNMAPPED_RD;
		end else if (rd_cap) begin
			avs_readdata_out <= next_readdata; // RULE13
		end
	end

	// analog side outputs
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			tap_code_out    <= '0;
			sample_hold_out <= 1'b0;
		end else begin
			tap_code_out    <= step.tap_code;
			sample_hold_out <= step.sampling;
		end
	end

	assign channel_number_out       = channel_select_reg; // RULE2
	assign comparator_power_out     = converter_mode_reg[MODE_ENABLE_BIT];
	assign analog_pin_count_out     = analog_pin_config_reg;
	assign port2_direction_bits_out = port2_direction_reg;
	assign conversion_irq_flag_out  = conversion_irq_flag;
endmodule

//--- sim/sar_adc_select_mode_control_asserts.sv
module sar_adc_select_mode_control_asserts
	import sar_adc_pkg::*;
(
	input wire logic              core_clk_in,
	input wire logic              rst_n_in,
	input wire logic [ADDR_W-1:0] avs_address_in,
	input wire logic              avs_write_in,
	input wire logic [DATA_W-1:0] avs_writedata_in,
	input wire logic [3:0]        avs_byteenable_in,
	input wire logic              avs_waitrequest_out,
	input wire logic [CODE_W-1:0] tap_code_out,
	input wire logic              sample_hold_out,
	input wire logic [CHAN_W-1:0] channel_number_out,
	input wire logic              comparator_power_out,
	input wire logic [PIN_W-1:0]  analog_pin_count_out,
	input wire logic              conversion_end_irq_out,
	input wire logic              conversion_irq_flag_out
);
	logic        acc;
	logic        mode_wr;
	logic        chan_wr;
	logic        pin_wr;
	logic [4:0]  time_q;
	logic        start_q;
	logic [7:0]  samp_cnt;
	logic        pend;
	logic [15:0] rcnt;
	assign acc = avs_write_in && !avs_waitrequest_out && avs_byteenable_in[0];
	assign mode_wr = acc && (avs_address_in == MODE_OFS);
	assign chan_wr = acc && (avs_address_in == CHAN_OFS);
	assign pin_wr = acc && (avs_address_in == PIN_OFS);
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			time_q <= 5'h00;
			start_q <= 1'b0;
		end else if (mode_wr) begin
			time_q <= avs_writedata_in[5:1];
			start_q <= avs_writedata_in[7];
		end
	end
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) samp_cnt <= 8'h00;
		else if (sample_hold_out) samp_cnt <= samp_cnt + 8'h01;
		else samp_cnt <= 8'h00;
	end
	always_ff @(posedge core_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pend <= 1'b0;
			rcnt <= 16'h0000;
		end else begin
			if (chan_wr) pend <= start_q;
			else if (mode_wr || conversion_end_irq_out) pend <= 1'b0;
			if (chan_wr) rcnt <= 16'h0000;
			else if (rcnt != 16'hFFFF) rcnt <= rcnt + 16'h0001;
		end
	end
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);
	a_irq_single_pulse: assert property (conversion_end_irq_out |=> !conversion_end_irq_out)
		else $error("end event longer than one cycle");
	a_irq_sets_flag: assert property (conversion_end_irq_out |-> conversion_irq_flag_out)
		else $error("end event without flag");
	a_stop_no_irq: assert property (!start_q |=> !conversion_end_irq_out)
		else $error("end event while stopped");
	a_cfg_write_wins: assert property ((mode_wr || chan_wr || pin_wr) |=> !conversion_end_irq_out)
		else $error("end event on config write edge");
	a_chan_field: assert property (chan_wr |=> channel_number_out == $past(avs_writedata_in[2:0]))
		else $error("channel field wrong");
	a_sample_length: assert property ($fell(sample_hold_out) && start_q
		|-> samp_cnt == (8'h04 + {3'h0, time_q}))
		else $error("sample phase length wrong");
	a_first_trial_msb: assert property ($fell(sample_hold_out) && start_q
		|-> ##[0:2] tap_code_out == 10'h200)
		else $error("first trial not bit 9");
	a_restart_time: assert property (conversion_end_irq_out && pend
		|-> rcnt >= 11 * (4 + time_q) && rcnt <= 11 * (4 + time_q) + 2)
		else $error("restart to end event time wrong");
	a_comp_power: assert property (mode_wr |=> comparator_power_out == $past(avs_writedata_in[0]))
		else $error("comparator enable wrong");
	a_pin_field: assert property (pin_wr |=> analog_pin_count_out == $past(avs_writedata_in[3:0]))
		else $error("pin config wrong");
	c_restart: cover property (conversion_end_irq_out && pend);
	c_sample: cover property ($fell(sample_hold_out) && start_q);
	c_stop: cover property (mode_wr && !avs_writedata_in[7]);
endmodule

bind sar_adc_select_mode_control sar_adc_select_mode_control_asserts u_asserts (
	.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .avs_address_in(avs_address_in),
	.avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
	.avs_byteenable_in(avs_byteenable_in), .avs_waitrequest_out(avs_waitrequest_out),
	.tap_code_out(tap_code_out), .sample_hold_out(sample_hold_out),
	.channel_number_out(channel_number_out), .comparator_power_out(comparator_power_out),
	.analog_pin_count_out(analog_pin_count_out),
	.conversion_end_irq_out(conversion_end_irq_out),
	.conversion_irq_flag_out(conversion_irq_flag_out));

//--- sim/test_sar_adc_select_mode_control.sv
module test_sar_adc_select_mode_control;
	timeunit 1ns;
	timeprecision 1ps;
	import sar_adc_pkg::*;
	logic              core_clk_in;
	logic              rst_n_in;
	logic [ADDR_W-1:0] avs_address_in;
	logic              avs_read_in;
	logic              avs_write_in;
	logic [DATA_W-1:0] avs_writedata_in;
	logic [DATA_W-1:0] avs_readdata_out;
	logic              avs_waitrequest_out;
	logic              comparator_in;
	logic [CODE_W-1:0] tap_code_out;
	logic [CHAN_W-1:0] channel_number_out;
	logic              conversion_end_irq_out;
	logic [CODE_W-1:0] chan_val [8];
	logic [DATA_W-1:0] rd;
	int                failures;
	int                n_tests;
	int                n;
	sar_adc_select_mode_control u_dut (
		.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .avs_address_in(avs_address_in),
		.avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
		.avs_writedata_in(avs_writedata_in), .avs_byteenable_in(4'h1),
		.avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
		.comparator_in(comparator_in), .tap_code_out(tap_code_out), .sample_hold_out(),
		.channel_number_out(channel_number_out), .comparator_power_out(),
		.analog_pin_count_out(), .port2_direction_bits_out(),
		.conversion_end_irq_out(conversion_end_irq_out), .conversion_irq_flag_out());
	always #2 core_clk_in = ~core_clk_in;
	// analog input per channel compared against the tap
	always @(posedge core_clk_in) comparator_in <= (chan_val[channel_number_out] >= tap_code_out);
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			failures++;
			$display("MISMATCH %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic bus_wr(input logic [7:0] a, input logic [7:0] d);
		int k = 0;
		logic w;
		avs_address_in <= a;
		avs_writedata_in <= {24'h000000, d};
		avs_write_in <= 1'b1;
		do begin
			@(negedge core_clk_in);
			w = avs_waitrequest_out;
			@(posedge core_clk_in);
			k++;
		end while (w !== 1'b0 && k < 50);
		if (w !== 1'b0) failures++;
		avs_write_in <= 1'b0;
		@(posedge core_clk_in);
	endtask
	task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
		int k = 0;
		logic w;
		avs_address_in <= a;
		avs_read_in <= 1'b1;
		do begin
			@(negedge core_clk_in);
			w = avs_waitrequest_out;
			@(posedge core_clk_in);
			k++;
		end while (w !== 1'b0 && k < 50);
		if (w !== 1'b0) failures++;
		d = avs_readdata_out;
		avs_read_in <= 1'b0;
		@(posedge core_clk_in);
	endtask
	task automatic wait_irq(output int c);
		c = 0;
		do begin @(negedge core_clk_in); c++; end while (conversion_end_irq_out !== 1'b1 && c < 2000);
		@(posedge core_clk_in);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		bus_rd(a, rd);
		check(rd, exp);
	endtask
	task automatic t_reset;
		rd_chk(RESULT_OFS, 32'h0000_0000);
		rd_chk(UPPER_OFS, 32'h0000_0000);
		rd_chk(PORT2_OFS, 32'h0000_00FF);
		rd_chk(8'h40, 32'h0000_0000);
	endtask
	task automatic t_convert;
		bus_wr(PIN_OFS, 8'h00);
		bus_wr(PORT2_OFS, 8'hFF);
		bus_wr(CHAN_OFS, 8'h00);
		bus_wr(MODE_OFS, 8'h05);
		repeat (260) @(posedge core_clk_in);
		bus_wr(MODE_OFS, 8'h85);
		wait_irq(n);
		wait_irq(n);
		check(32'(n), 32'd66);
		rd_chk(RESULT_OFS, {16'h0000, chan_val[0], 6'h00});
		rd_chk(UPPER_OFS, {24'h000000, chan_val[0][9:2]});
		rd_chk(FLAG_OFS, 32'h0000_0001);
		bus_wr(FLAG_OFS, 8'h00);
		rd_chk(FLAG_OFS, 32'h0000_0000);
	endtask
	task automatic t_channels;
		for (int i = 1; i <= 8; i++) begin
			repeat (20) @(posedge core_clk_in);
			bus_wr(CHAN_OFS, 8'(i % 8));
			wait_irq(n);
			check(32'(n), 32'd67);
			rd_chk(RESULT_OFS, {16'h0000, chan_val[i % 8], 6'h00});
		end
	endtask
	task automatic t_stop;
		int hits = 0;
		repeat (20) @(posedge core_clk_in);
		bus_wr(MODE_OFS, 8'h05);
		repeat (200) begin
			@(negedge core_clk_in);
			if (conversion_end_irq_out !== 1'b0) hits++;
		end
		@(posedge core_clk_in);
		check(32'(hits), 32'd0);
		rd_chk(RESULT_OFS, {16'h0000, chan_val[0], 6'h00});
	endtask
	task automatic t_time_and_off;
		bus_wr(MODE_OFS, 8'h89);
		wait_irq(n);
		wait_irq(n);
		check(32'(n), 32'd88);
		repeat (20) @(posedge core_clk_in);
		bus_wr(MODE_OFS, 8'h84);
		wait_irq(n);
		wait_irq(n);
		rd_chk(RESULT_OFS, 32'h0000_0000);
		rd_chk(STATUS_OFS, 32'h0000_0005);
		repeat (20) @(posedge core_clk_in);
		bus_wr(MODE_OFS, 8'h00);
	endtask
	task automatic conclude;
		$display("counts: failures %0d comparisons %0d", failures, n_tests);
		if (failures == 0 && n_tests > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#100000;
		failures++;
		conclude();
	end
	initial begin
		chan_val = '{10'h2A5, 10'h3FF, 10'h000, 10'h155, 10'h001, 10'h200, 10'h1FF, 10'h0C3};
		failures = 0;
		n_tests = 0;
		core_clk_in = 1'b0;
		rst_n_in = 1'b0;
		avs_address_in = 8'h00;
		avs_read_in = 1'b0;
		avs_write_in = 1'b0;
		avs_writedata_in = 32'h0000_0000;
		comparator_in = 1'b0;
		repeat (2) @(posedge core_clk_in);
		rst_n_in <= 1'b1;
		@(posedge core_clk_in);
		t_reset();
		t_convert();
		t_channels();
		t_stop();
		t_time_and_off();
		conclude();
	end
endmodule
